// File: lsth_pkg.sv
// package: offsets, field positions and reset values of the low-speed
// threshold and first root hub descriptor registers
// assumes: byte-addressed register access from the core's register decode
package lsth_pkg;
	// register byte offsets from the base address
	localparam logic [7:0] offset_low_speed_start_threshold = 8'h44;
	localparam logic [7:0] offset_root_hub_descriptor_first = 8'h48;
	// threshold field
	localparam int threshold_width = 12;
	localparam logic [11:0] threshold_reset = 12'h628;
	// frame remaining counter width
	localparam int frame_width = 14;
	// descriptor field positions
	localparam int pos_power_on_to_good_time = 24;
	localparam int pos_no_overcurrent_protect = 12;
	localparam int pos_overcurrent_report_mode = 11;
	localparam int pos_compound_device_flag = 10;
	localparam int pos_ports_always_powered = 9;
	localparam int pos_power_switch_mode = 8;
	// descriptor reset values
	localparam logic [7:0] power_on_to_good_time_reset = 8'hff;
	localparam logic no_overcurrent_protect_reset = 1'b0;
	localparam logic overcurrent_report_mode_reset = 1'b1;
	localparam logic ports_always_powered_reset = 1'b0;
	localparam logic power_switch_mode_reset = 1'b1;
	localparam logic [7:0] downstream_port_count_value = 8'h01;
	// writable bits of the descriptor word
	localparam logic [31:0] descriptor_write_mask = 32'hff001b00;
	// pipeline latency of the start decision
	localparam int decide_latency = 1;
endpackage : lsth_pkg

// File: lsth_decide.sv
// low-speed start decision: compares remaining frame time with threshold
// assumes: frame_time_remaining counts down within a frame, core clock
`timescale 1ns/1ps
module lsth_decide (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [13:0] frame_time_remaining,
	input wire logic [11:0] low_speed_threshold_value,
	output logic low_speed_start_allowed
);
	// whole state in one struct
	typedef struct packed {
		logic allowed;
	} decide_state_type;
	decide_state_type state;
	decide_state_type next_state;

	// compare against the zero-extended threshold
	always_comb begin
		next_state = state;
		next_state.allowed = (frame_time_remaining >=
			{2'b00, low_speed_threshold_value});
	end

	// register the decision so the output is glitch free
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign low_speed_start_allowed = state.allowed;
endmodule : lsth_decide

// File: lsth_regs.sv
// file: register bank holding the low-speed threshold and first root hub
// descriptor, plus the low-speed start decision
// assumes: core decode gives byte address, write and read strobes; reads
// answer one cycle after the strobe
`timescale 1ns/1ps
module lsth_regs (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [7:0] reg_address,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_write_data,
	input wire logic [13:0] frame_time_remaining,
	output logic [31:0] reg_read_data,
	output logic low_speed_start_allowed,
	output logic [7:0] power_on_to_good_time,
	output logic overcurrent_per_port,
	output logic power_per_port,
	output logic [7:0] downstream_port_count
);
	// two-flop reset release
	logic [1:0] reset_sync;
	logic rst_n;

	// all register state except reset_sync in one struct
	typedef struct packed {
		logic [11:0] threshold;
		logic [7:0] good_time;
		logic no_ocp;
		logic ocp_mode;
		logic always_powered;
		logic switch_mode;
		logic [31:0] read_data;
		logic oc_per_port;
		logic pw_per_port;
	} regs_state_type;
	regs_state_type state;
	regs_state_type next_state;
	logic [31:0] desc_word;
	logic [31:0] merged;
	logic decide_out;

	// reset release: async assert, sync deassert
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			reset_sync <= 2'b00;
		end else begin
			reset_sync <= {reset_sync[0], 1'b1};
		end
	end
	assign rst_n = reset_sync[1];

	// assemble the descriptor read word
	always_comb begin
		desc_word = '0;
		desc_word[31:24] = state.good_time;
		desc_word[lsth_pkg::pos_no_overcurrent_protect] = state.no_ocp;
		desc_word[lsth_pkg::pos_overcurrent_report_mode] = state.ocp_mode;
		// root hub never compound, bit tied low
		desc_word[lsth_pkg::pos_compound_device_flag] = 1'b0;
		desc_word[lsth_pkg::pos_ports_always_powered] = state.always_powered;
		desc_word[lsth_pkg::pos_power_switch_mode] = state.switch_mode;
		desc_word[7:0] = lsth_pkg::downstream_port_count_value;
		// only writable bits take the written word; the rest keep theirs
		merged = (reg_write_data & lsth_pkg::descriptor_write_mask) |
			(desc_word & ~lsth_pkg::descriptor_write_mask);
	end

	// next-state logic: writes, read capture, mode decode
	always_comb begin
		next_state = state;
		// threshold is changed only by a bus write or by reset, never by other hardware
		if (reg_write &&
			reg_address == lsth_pkg::offset_low_speed_start_threshold) begin
			next_state.threshold = reg_write_data[11:0];
		end
		if (reg_write &&
			reg_address == lsth_pkg::offset_root_hub_descriptor_first) begin
			next_state.good_time = merged[31:24];
			next_state.no_ocp = merged[lsth_pkg::pos_no_overcurrent_protect];
			next_state.ocp_mode = merged[lsth_pkg::pos_overcurrent_report_mode];
			next_state.always_powered =
				merged[lsth_pkg::pos_ports_always_powered];
			next_state.switch_mode = merged[lsth_pkg::pos_power_switch_mode];
		end
		// read data; reserved and unmapped read zero
		if (reg_read) begin
			case (reg_address)
				lsth_pkg::offset_low_speed_start_threshold: begin
					next_state.read_data = {20'h00000, state.threshold};
				end
				lsth_pkg::offset_root_hub_descriptor_first: begin
					next_state.read_data = desc_word;
				end
				default: begin
					next_state.read_data = 32'h00000000;
				end
			endcase
		end
		// per-port overcurrent only with protection present
		next_state.oc_per_port = !state.no_ocp && state.ocp_mode;
		// per-port power only when ports are switched
		next_state.pw_per_port = !state.always_powered &&
			state.switch_mode;
	end

	// state register; reset values fixed by this board arrangement
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state.threshold <= lsth_pkg::threshold_reset;
			state.good_time <= lsth_pkg::power_on_to_good_time_reset;
			state.no_ocp <= lsth_pkg::no_overcurrent_protect_reset;
			state.ocp_mode <= lsth_pkg::overcurrent_report_mode_reset;
			state.always_powered <= lsth_pkg::ports_always_powered_reset;
			state.switch_mode <= lsth_pkg::power_switch_mode_reset;
			state.read_data <= 32'h00000000;
			state.oc_per_port <= 1'b1;
			state.pw_per_port <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// start decision, registered inside the leaf
	lsth_decide u_decide (
		.clock(clock),
		.reset_n(rst_n),
		.frame_time_remaining(frame_time_remaining),
		.low_speed_threshold_value(state.threshold),
		.low_speed_start_allowed(decide_out)
	);

	assign reg_read_data = state.read_data;
	assign low_speed_start_allowed = decide_out;
	// good time in 2 ms units; host software does the waiting
	assign power_on_to_good_time = state.good_time;
	assign overcurrent_per_port = state.oc_per_port;
	assign power_per_port = state.pw_per_port;
	assign downstream_port_count = lsth_pkg::downstream_port_count_value;

	// decision follows the comparison one cycle later
	property p_start_decision;
		@(posedge clock) disable iff (!rst_n)
		1'b1 |=> low_speed_start_allowed ==
			($past(frame_time_remaining) >= {2'b00, $past(state.threshold)});
	endproperty
	a_start_decision: assert property (p_start_decision)
		else $error("low-speed start decision wrong");

	// threshold moves only on a write to its offset
	property p_threshold_stable;
		@(posedge clock) disable iff (!rst_n)
		!(reg_write &&
			reg_address == lsth_pkg::offset_low_speed_start_threshold)
		|=> $stable(state.threshold);
	endproperty
	a_threshold_stable: assert property (p_threshold_stable)
		else $error("threshold changed without a write");

	// compound flag never reads one
	property p_compound_zero;
		@(posedge clock) disable iff (!rst_n)
		reg_read && reg_address == lsth_pkg::offset_root_hub_descriptor_first
		|=> reg_read_data[10] == 1'b0;
	endproperty
	a_compound_zero: assert property (p_compound_zero)
		else $error("compound device bit read as one");

	// descriptor read shows port count
	property p_port_count;
		@(posedge clock) disable iff (!rst_n)
		reg_read && reg_address == lsth_pkg::offset_root_hub_descriptor_first
		|=> reg_read_data[7:0] == 8'h01;
	endproperty
	a_port_count: assert property (p_port_count)
		else $error("port count field wrong");

	// threshold read reflects stored value, reserved zero
	property p_threshold_read;
		@(posedge clock) disable iff (!rst_n)
		reg_read &&
			reg_address == lsth_pkg::offset_low_speed_start_threshold
		|=> reg_read_data == {20'h00000, $past(state.threshold)};
	endproperty
	a_threshold_read: assert property (p_threshold_read)
		else $error("threshold read data wrong");

	// overcurrent mode decode two cycles after a descriptor write
	property p_ocp_mode;
		@(posedge clock) disable iff (!rst_n)
		reg_write && reg_address == lsth_pkg::offset_root_hub_descriptor_first
		|=> ##1 overcurrent_per_port ==
			(!$past(reg_write_data[12], 2) && $past(reg_write_data[11], 2));
	endproperty
	a_ocp_mode: assert property (p_ocp_mode)
		else $error("overcurrent mode decode wrong");

	// power switch decode two cycles after a descriptor write
	property p_power_mode;
		@(posedge clock) disable iff (!rst_n)
		reg_write && reg_address == lsth_pkg::offset_root_hub_descriptor_first
		|=> ##1 power_per_port ==
			(!$past(reg_write_data[9], 2) && $past(reg_write_data[8], 2));
	endproperty
	a_power_mode: assert property (p_power_mode)
		else $error("power switch decode wrong");

	// reset values right at the first cycle after release
	property p_reset_values;
		@(posedge clock)
		$rose(rst_n) |-> state.threshold == 12'h628 &&
			desc_word == 32'hff000901;
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("reset values wrong");

	// unmapped reads answer zero
	property p_unmapped;
		@(posedge clock) disable iff (!rst_n)
		reg_read &&
			reg_address != lsth_pkg::offset_low_speed_start_threshold &&
			reg_address != lsth_pkg::offset_root_hub_descriptor_first
		|=> reg_read_data == 32'h00000000;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
endmodule : lsth_regs

// File: tb_low_speed_threshold_root_hub_desc.sv
// testbench: register reads and writes plus start decision of lsth_regs
// assumes: lsth_pkg compiled first; inputs change on the falling edge
`timescale 1ns/1ps
module tb_low_speed_threshold_root_hub_desc;
	logic clock; // 50 MHz core clock
	logic reset_n; // async reset, active low
	logic [7:0] reg_address; // byte offset of the access
	logic reg_write; // write strobe
	logic reg_read; // read strobe
	logic [31:0] reg_write_data; // write word
	logic [13:0] frame_time_remaining; // remaining frame count
	logic [31:0] reg_read_data;
	logic low_speed_start_allowed;
	logic [7:0] power_on_to_good_time;
	logic overcurrent_per_port;
	logic power_per_port;
	logic [7:0] downstream_port_count;
	int mismatches; // failed comparisons
	int compares; // all comparisons
	// descriptor writes with the word and mode outputs they should give
	logic [31:0] desc_in [3] = '{32'hffffffff, 32'h00000800, 32'h00000100};
	logic [31:0] desc_out [3] = '{32'hff001b01, 32'h00000801, 32'h00000101};
	logic [1:0] modes [3] = '{2'b00, 2'b10, 2'b01};
	localparam logic [7:0] thr = lsth_pkg::offset_low_speed_start_threshold;
	localparam logic [7:0] desc = lsth_pkg::offset_root_hub_descriptor_first;

	lsth_regs uut (
		.clock(clock),
		.reset_n(reset_n),
		.reg_address(reg_address),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.reg_write_data(reg_write_data),
		.frame_time_remaining(frame_time_remaining),
		.reg_read_data(reg_read_data),
		.low_speed_start_allowed(low_speed_start_allowed),
		.power_on_to_good_time(power_on_to_good_time),
		.overcurrent_per_port(overcurrent_per_port),
		.power_per_port(power_per_port),
		.downstream_port_count(downstream_port_count)
	);

	// free-running clock, 20 ns period
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// verdict in one place for both the tests and the watchdog
	task report_and_stop;
		if (mismatches == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop

	// register word comparison
	task check_word(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : check_word

	// output pin comparison, narrow pins zero-extended by the caller
	task check_pin(input string name, input logic [7:0] exp,
		input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : check_pin

	// reset held six cycles, then room for the two-stage release
	task do_reset;
		@(negedge clock);
		reset_n = 1'b0;
		repeat (6) @(negedge clock);
		reset_n = 1'b1;
		repeat (4) @(negedge clock);
	endtask : do_reset

	// one-cycle write strobe, whole word
	task reg_put(input logic [7:0] a, input logic [31:0] d);
		@(negedge clock);
		reg_address = a;
		reg_write_data = d;
		reg_write = 1'b1;
		@(negedge clock);
		reg_write = 1'b0;
	endtask : reg_put

	// one-cycle read strobe; data stands, so it is looked at a cycle later
	task reg_get(input logic [7:0] a, input logic [31:0] exp);
		@(negedge clock);
		reg_address = a;
		reg_read = 1'b1;
		@(negedge clock);
		reg_read = 1'b0;
		@(negedge clock);
		check_word("read data", exp, reg_read_data);
	endtask : reg_get

	// frame count held steady long enough for the registered decision
	task decide(input logic [13:0] f, input logic exp);
		@(negedge clock);
		frame_time_remaining = f;
		repeat (3) @(negedge clock);
		check_pin("start allowed", {7'h00, exp},
			{7'h00, low_speed_start_allowed});
	endtask : decide

	// watchdog: the whole sequence needs well under 2000 cycles
	initial begin
		#(20 * 2000);
		mismatches++;
		report_and_stop();
	end

	// main sequence
	initial begin
		mismatches = 0;
		compares = 0;
		reset_n = 1'b1;
		reg_address = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_write_data = 32'h00000000;
		frame_time_remaining = 14'h0000;
		do_reset();
		reg_get(thr, 32'h00000628);
		reg_get(desc, 32'hff000901);
		check_pin("good time", 8'hff, power_on_to_good_time);
		check_pin("ports", 8'h01, downstream_port_count);
		check_pin("modes", 8'h03, {6'h00, overcurrent_per_port,
			power_per_port});
		decide(14'h0628, 1'b1);
		decide(14'h0627, 1'b0);
		// the decoded modes follow the stored disable and mode bits
		for (int i = 0; i < 3; i++) begin
			reg_put(desc, desc_in[i]);
			reg_get(desc, desc_out[i]);
			check_pin("modes", {6'h00, modes[i]}, {6'h00,
				overcurrent_per_port, power_per_port});
			// software reads this byte to time its port power-up wait
			check_pin("good time", desc_in[i][31:24],
				power_on_to_good_time);
		end
		// reserved bits dropped, only the twelve threshold bits kept
		reg_put(thr, 32'hfffff100);
		reg_get(thr, 32'h00000100);
		decide(14'h0100, 1'b1);
		decide(14'h00ff, 1'b0);
		decide(14'h3fff, 1'b1);
		// well-behaved software write: reserved bits kept at zero
		reg_put(thr, 32'h00000fff);
		decide(14'h0ffe, 1'b0);
		decide(14'h1000, 1'b1);
		reg_put(thr, 32'h00000000);
		decide(14'h0000, 1'b1);
		reg_get(thr, 32'h00000000);
		// unmapped place: reads zero, writes touch nothing
		reg_put(8'h4c, 32'hffffffff);
		reg_get(8'h4c, 32'h00000000);
		reg_get(desc, 32'h00000101);
		// second reset in mid-run restores both words
		do_reset();
		reg_get(thr, 32'h00000628);
		reg_get(desc, 32'hff000901);
		report_and_stop();
	end
endmodule : tb_low_speed_threshold_root_hub_desc
